/* File: osc_settle_counter.sv */
// main_xtal_osc settle counter with thermometer status bits
`timescale 1ns/1ps
`include "stby_consts.svh"
module osc_settle_counter
  import stby_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rstn_i, // sync reset, active low
  settle_if.cnt sif // control side
);
  logic [18:0] cnt_ff;
  logic [7:0] status_ff;
  logic [18:0] lim;

  assign lim = settle_thr(sif.sel);

  ////////////////////////////////////////////////////////////////
  // counts crystal edges only, so time before oscillation is skipped
  always_ff @(posedge clk_i) begin
    if (!rstn_i || sif.clear) begin
      cnt_ff <= 19'h00000;
    end else if (sif.x1_tick && cnt_ff < lim) begin
      cnt_ff <= cnt_ff + 19'h00001;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_stat
      always_ff @(posedge clk_i) begin
        if (!rstn_i || sif.clear) begin
          status_ff[g] <= 1'b0;
        end else if (3'(g) <= sif.sel && cnt_ff >= settle_thr(3'(g))) begin
          status_ff[g] <= 1'b1;
        end
      end
    end
  endgenerate

  assign sif.status = status_ff;
  assign sif.done = status_ff[sif.sel];

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_status_thermo: assert property ((status_ff & (status_ff + 8'h01)) == 8'h00)
    else $error("settle status not thermometer");
  a_status_cap: assert property ($countones(status_ff) <= 32'(sif.sel) + 1)
    else $error("settle status beyond selected code");
  a_clear_zero: assert property (sif.clear |=> status_ff == `SETTLE_STATUS_RST)
    else $error("settle status not cleared");
  c_settle_full: cover property (status_ff == 8'hFF);
endmodule

/* File: settle_if.sv */
// link between the standby control and the settle counter
`timescale 1ns/1ps
interface settle_if;
  logic x1_tick;
  logic clear;
  logic [2:0] sel;
  logic [7:0] status;
  logic done;
  modport ctrl (output x1_tick, output clear, output sel, input status, input done);
  modport cnt (input x1_tick, input clear, input sel, output status, output done);
endinterface

/* File: standby_halt_osc_settle.sv */
// standby control: halt and stop sequencing plus settle registers
`timescale 1ns/1ps
`include "stby_consts.svh"
module standby_halt_osc_settle
  import stby_pkg::*;
(
  input wire logic clk_i, // system clock, 250 MHz
  input wire logic rstn_i, // sync reset, active low
  input wire logic x1_clk_i, // main_xtal_osc clock pin
  input wire logic [19:0] addr_i, // cpu data address
  input wire logic rd_i, // cpu read strobe
  input wire logic wr_i, // cpu write strobe
  input wire logic bit_op_i, // access is a 1-bit operation
  input wire logic [2:0] bit_idx_i, // bit number of 1-bit access
  input wire logic [7:0] wdata_i, // cpu write data
  output logic [7:0] rdata_o, // cpu read data
  input wire logic halt_exec_i, // halt instruction executed
  input wire logic stop_exec_i, // stop instruction executed
  input clk_src_t clk_src_i, // present cpu clock source
  input wire logic main_osc_halt_ctrl_i, // main oscillator stop bit
  input wire logic [`IRQ_NUM-1:0] irq_flag_i, // interrupt request flags
  input wire logic [`IRQ_NUM-1:0] irq_mask_i, // interrupt mask flags
  input wire logic int_ack_en_i, // interrupt acknowledge enabled
  input wire logic watchdog_on_opt_i, // option: watchdog enable
  input wire logic watchdog_standby_run_opt_i, // option: run in standby
  output logic cpu_clk_en_o, // clock delivered to cpu
  output logic standby_o, // in halt or stop
  output logic resume_o, // one-cycle pulse: cpu restarts
  output logic vector_take_o, // restart takes interrupt vector
  output logic flash_lowpwr_o, // flash in low-current wait
  output logic adc_en_o, // a/d converter may run
  output logic i2c_en_o, // i2c_serial_unit may run
  output logic lso_run_o, // low-speed oscillator runs
  output logic wdt_run_o, // watchdog counts
  output logic x1_allow_o, // crystal source may oscillate
  output logic ext_allow_o, // external clock input may run
  output logic port_hold_o // ram and port latches frozen
);
  ////////////////////////////////////////////////////////////////
  // crystal pin synchroniser and edge detect
  logic x1_meta_ff;
  logic x1_sync_ff;
  logic x1_prev_ff;

  always_ff @(posedge clk_i) begin
    x1_meta_ff <= x1_clk_i;
    x1_sync_ff <= x1_meta_ff;
    x1_prev_ff <= x1_sync_ff;
  end

  settle_if sif ();

  osc_settle_counter u_cnt (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .sif(sif)
  );

  ////////////////////////////////////////////////////////////////
  // select register
  logic [2:0] sel_ff;
  logic sel_wr;
  logic stat_hit;
  logic sel_hit;

  assign stat_hit = addr_i == `ADDR_SETTLE_STATUS;
  assign sel_hit = addr_i == `ADDR_SETTLE_SELECT;
  assign sel_wr = wr_i && sel_hit && !bit_op_i;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sel_ff <= `SETTLE_SELECT_RST;
    end else if (sel_wr) begin
      sel_ff <= wdata_i[`SEL_CODE_MSB:`SEL_CODE_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////
  // state machine
  stby_state_t state_ff;
  stby_state_t nxt_state;
  logic [3:0] wait_ff;
  logic [3:0] nxt_wait;
  logic sub_ff;
  logic x1_src_ff;
  logic vec_ff;
  logic nxt_vec;
  logic pending;
  logic stop_ok;
  logic stop_go;
  logic [3:0] wake_len;

  assign pending = |(irq_flag_i & ~irq_mask_i);
  assign stop_ok = clk_src_i != SRC_IH40 && clk_src_i != SRC_SUB;
  assign stop_go = state_ff == ST_RUN && stop_exec_i && stop_ok;

  always_comb begin
    if (sub_ff) begin
      wake_len = int_ack_en_i ? `WAIT_SUB_VEC : `WAIT_SUB_NOVEC;
    end else begin
      wake_len = int_ack_en_i ? `WAIT_MAIN_VEC : `WAIT_MAIN_NOVEC;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_wait = wait_ff;
    nxt_vec = vec_ff;
    case (state_ff)
      ST_RUN: begin
        if (halt_exec_i) begin
          nxt_state = ST_HALT;
        end else if (stop_go) begin
          nxt_state = ST_STOP;
        end
      end
      ST_HALT: begin
        if (pending) begin
          nxt_state = ST_WAKE;
          nxt_wait = wake_len - `WAIT_LOAD_OFS;
          nxt_vec = int_ack_en_i;
        end
      end
      ST_STOP: begin
        if (pending) begin
          nxt_vec = int_ack_en_i;
          if (x1_src_ff) begin
            nxt_state = ST_SETTLE;
          end else begin
            nxt_state = ST_WAKE;
            nxt_wait = wake_len - `WAIT_LOAD_OFS;
          end
        end
      end
      ST_SETTLE: begin
        if (sif.done) begin
          nxt_state = ST_WAKE;
          nxt_wait = wake_len - `WAIT_LOAD_OFS;
        end
      end
      ST_WAKE: begin
        if (wait_ff == 4'h0) begin
          nxt_state = ST_RUN;
        end else begin
          nxt_wait = wait_ff - 4'h1;
        end
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_ff <= ST_RUN;
      wait_ff <= 4'h0;
      vec_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      wait_ff <= nxt_wait;
      vec_ff <= nxt_vec;
    end
  end

  // source seen at entry decides wait length and settle need
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sub_ff <= 1'b0;
      x1_src_ff <= 1'b0;
    end else if (state_ff == ST_RUN && (halt_exec_i || stop_go)) begin
      sub_ff <= clk_src_i == SRC_SUB;
      x1_src_ff <= clk_src_i == SRC_X1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // counter control
  assign sif.x1_tick = x1_sync_ff && !x1_prev_ff;
  assign sif.clear = stop_go || main_osc_halt_ctrl_i;
  assign sif.sel = sel_ff;

  ////////////////////////////////////////////////////////////////
  // register read port
  logic [7:0] rdata_ff;
  logic [7:0] rd_byte;

  always_comb begin
    if (stat_hit) begin
      rd_byte = sif.status;
    end else if (sel_hit) begin
      rd_byte = {5'h00, sel_ff};
    end else begin
      rd_byte = 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_ff <= 8'h00;
    end else if (rd_i) begin
      rdata_ff <= bit_op_i ? {7'h00, rd_byte[bit_idx_i]} : rd_byte;
    end
  end

  ////////////////////////////////////////////////////////////////
  // operating status outputs, all but x1_allow and ext_allow taken from the next state
  logic cpu_clk_en_ff;
  logic standby_ff;
  logic resume_ff;
  logic flash_lowpwr_ff;
  logic adc_en_ff;
  logic i2c_en_ff;
  logic lso_run_ff;
  logic wdt_run_ff;
  logic x1_allow_ff;
  logic ext_allow_ff;
  logic nxt_stby;
  logic nxt_sub_halt;
  logic nxt_sub;
  logic wd_ok;

  assign nxt_stby = nxt_state != ST_RUN && nxt_state != ST_WAKE;
  assign nxt_sub = (state_ff == ST_RUN) ? clk_src_i == SRC_SUB : sub_ff;
  assign nxt_sub_halt = nxt_state == ST_HALT && nxt_sub;
  assign wd_ok = watchdog_on_opt_i && watchdog_standby_run_opt_i;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cpu_clk_en_ff <= 1'b1;
      standby_ff <= 1'b0;
      resume_ff <= 1'b0;
    end else begin
      cpu_clk_en_ff <= nxt_state == ST_RUN;
      standby_ff <= nxt_stby;
      resume_ff <= state_ff == ST_WAKE && nxt_state == ST_RUN;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      flash_lowpwr_ff <= 1'b0;
      adc_en_ff <= 1'b1;
      i2c_en_ff <= 1'b1;
    end else begin
      flash_lowpwr_ff <= nxt_sub_halt;
      adc_en_ff <= !(nxt_sub_halt || nxt_state == ST_STOP || nxt_state == ST_SETTLE);
      i2c_en_ff <= !(nxt_sub_halt || nxt_state == ST_STOP || nxt_state == ST_SETTLE);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      lso_run_ff <= 1'b1;
      wdt_run_ff <= 1'b0;
    end else begin
      lso_run_ff <= nxt_stby ? wd_ok : 1'b1;
      wdt_run_ff <= nxt_stby ? wd_ok : watchdog_on_opt_i;
    end
  end

  // an unused crystal or external source cannot run beside the other
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      x1_allow_ff <= 1'b1;
      ext_allow_ff <= 1'b1;
    end else begin
      x1_allow_ff <= clk_src_i != SRC_EXT;
      ext_allow_ff <= clk_src_i != SRC_X1;
    end
  end

  assign rdata_o = rdata_ff;
  assign cpu_clk_en_o = cpu_clk_en_ff;
  assign standby_o = standby_ff;
  assign resume_o = resume_ff;
  assign vector_take_o = vec_ff;
  assign flash_lowpwr_o = flash_lowpwr_ff;
  assign adc_en_o = adc_en_ff;
  assign i2c_en_o = i2c_en_ff;
  assign lso_run_o = lso_run_ff;
  assign wdt_run_o = wdt_run_ff;
  assign x1_allow_o = x1_allow_ff;
  assign ext_allow_o = ext_allow_ff;
  assign port_hold_o = standby_ff;

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_sel_reset: assert property ($past(!rstn_i) |-> sel_ff == `SETTLE_SELECT_RST)
    else $error("select not seven after reset");
  a_sel_byte_wr: assert property (sel_wr |=> sel_ff == $past(wdata_i[2:0]))
    else $error("byte write to select lost");
  a_sel_bit_wr: assert property (wr_i && sel_hit && bit_op_i |=> $stable(sel_ff))
    else $error("bit write changed select");
  a_bit_read: assert property (rd_i && stat_hit && bit_op_i
    |=> rdata_o == {7'h00, $past(sif.status[bit_idx_i])})
    else $error("status bit read wrong");
  a_halt_gates_clk: assert property (state_ff == ST_HALT |-> !cpu_clk_en_o)
    else $error("cpu clock runs in halt");
  a_wake_main_vec: assert property (state_ff == ST_HALT && pending && int_ack_en_i && !sub_ff
    |=> !resume_o [*8] ##1 !resume_o ##1 resume_o)
    else $error("vectored main wake not ten cycles");
  a_wake_sub_novec: assert property (state_ff == ST_HALT && pending && !int_ack_en_i && sub_ff
    |-> ##3 resume_o)
    else $error("plain sub wake not three cycles");
  a_halt_release: assert property (state_ff == ST_HALT && pending |=> state_ff == ST_WAKE)
    else $error("pending request did not release halt");
  a_sub_halt_off: assert property (state_ff == ST_HALT && sub_ff
    |-> flash_lowpwr_o && !adc_en_o && !i2c_en_o)
    else $error("sub halt peripherals wrong");
  a_lso_halt: assert property (state_ff == ST_HALT |-> lso_run_o == wd_ok)
    else $error("low-speed osc wrong in halt");
  a_settle_hold: assert property (state_ff == ST_SETTLE && !sif.done |=> !cpu_clk_en_o)
    else $error("cpu released before settle");
  a_reset_run: assert property ($past(!rstn_i) |-> state_ff == ST_RUN)
    else $error("reset did not return to run");

  c_halt_resume: cover property (state_ff == ST_HALT ##[1:20] resume_o);
  c_stop_settle: cover property (state_ff == ST_SETTLE ##1 state_ff == ST_WAKE);
  c_bit_read: cover property (rd_i && stat_hit && bit_op_i);
endmodule

/* File: stby_consts.svh */
// constants for the standby and oscillator settle block
`ifndef STBY_CONSTS_SVH
`define STBY_CONSTS_SVH
`define ADDR_SETTLE_STATUS 20'hFFFA2
`define ADDR_SETTLE_SELECT 20'hFFFA3
`define SETTLE_STATUS_RST 8'h00
`define SETTLE_SELECT_RST 3'h7
`define SEL_CODE_MSB 2
`define SEL_CODE_LSB 0
`define SETTLE_EXP0 5'h08
`define SETTLE_EXP1 5'h09
`define SETTLE_EXP2 5'h0A
`define SETTLE_EXP3 5'h0B
`define SETTLE_EXP4 5'h0D
`define SETTLE_EXP5 5'h0F
`define SETTLE_EXP6 5'h11
`define SETTLE_EXP7 5'h12
`define WAIT_MAIN_VEC 4'hA
`define WAIT_MAIN_NOVEC 4'h5
`define WAIT_SUB_VEC 4'h8
`define WAIT_SUB_NOVEC 4'h3
`define WAIT_LOAD_OFS 4'h2
`define IRQ_NUM 8
`endif

/* File: stby_pkg.sv */
// types and threshold decode for the standby block
`include "stby_consts.svh"
package stby_pkg;
  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_HALT = 5'h02,
    ST_STOP = 5'h04,
    ST_SETTLE = 5'h08,
    ST_WAKE = 5'h10
  } stby_state_t;

  typedef enum logic [2:0] {
    SRC_IH = 3'h0,
    SRC_IH40 = 3'h1,
    SRC_X1 = 3'h2,
    SRC_EXT = 3'h3,
    SRC_SUB = 3'h4
  } clk_src_t;

  // settle threshold in main_xtal_osc cycles for a select code
  function automatic logic [18:0] settle_thr(input logic [2:0] code);
    logic [4:0] e;
    case (code)
      3'h0: e = `SETTLE_EXP0;
      3'h1: e = `SETTLE_EXP1;
      3'h2: e = `SETTLE_EXP2;
      3'h3: e = `SETTLE_EXP3;
      3'h4: e = `SETTLE_EXP4;
      3'h5: e = `SETTLE_EXP5;
      3'h6: e = `SETTLE_EXP6;
      default: e = `SETTLE_EXP7;
    endcase
    return 19'h00001 << e;
  endfunction
endpackage

/* File: tb.sv */
// self-checking bench for the standby and settle block
`timescale 1ns/1ps
`include "stby_consts.svh"
module tb
  import stby_pkg::*;
;
  logic clk_i = 1'b0, rstn_i = 1'b0, rd_i = 1'b0, wr_i = 1'b0, bit_op_i = 1'b0;
  logic [19:0] addr_i = 20'h00000;
  logic [2:0] bit_idx_i = 3'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o, irq_flag_i = 8'h00, irq_mask_i = 8'hFF;
  logic halt_exec_i = 1'b0, stop_exec_i = 1'b0, main_osc_halt_ctrl_i = 1'b0;
  logic int_ack_en_i = 1'b0, watchdog_on_opt_i = 1'b0, watchdog_standby_run_opt_i = 1'b0;
  clk_src_t clk_src_i = SRC_IH;
  logic cpu_clk_en_o, standby_o, resume_o, vector_take_o, flash_lowpwr_o, adc_en_o;
  logic i2c_en_o, lso_run_o, wdt_run_o, x1_allow_o, ext_allow_o, port_hold_o, x1_clk, osc_on = 1'b0;
  int fail_count = 0, n_checks = 0, cyc = 0;
  logic [31:0] seed = 32'hC412;
  //////////////////////////////////////////////////////////////////////////////
  standby_halt_osc_settle u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .x1_clk_i(x1_clk),
    .addr_i(addr_i), .rd_i(rd_i), .wr_i(wr_i), .bit_op_i(bit_op_i), .bit_idx_i(bit_idx_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .halt_exec_i(halt_exec_i), .stop_exec_i(stop_exec_i),
    .clk_src_i(clk_src_i), .main_osc_halt_ctrl_i(main_osc_halt_ctrl_i), .irq_flag_i(irq_flag_i),
    .irq_mask_i(irq_mask_i), .int_ack_en_i(int_ack_en_i), .watchdog_on_opt_i(watchdog_on_opt_i),
    .watchdog_standby_run_opt_i(watchdog_standby_run_opt_i), .cpu_clk_en_o(cpu_clk_en_o),
    .standby_o(standby_o), .resume_o(resume_o), .vector_take_o(vector_take_o),
    .flash_lowpwr_o(flash_lowpwr_o), .adc_en_o(adc_en_o), .i2c_en_o(i2c_en_o),
    .lso_run_o(lso_run_o), .wdt_run_o(wdt_run_o), .x1_allow_o(x1_allow_o),
    .ext_allow_o(ext_allow_o), .port_hold_o(port_hold_o));
  x1_osc_model u_osc (.en_i(osc_on & x1_allow_o), .x1_o(x1_clk));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // status with bits 0..c set
  function automatic logic [7:0] therm(input logic [2:0] c);
    logic [8:0] t;
    t = (9'h002 << c) - 9'h001;
    return t[7:0];
  endfunction
  function automatic int wake_w(input logic sub, input logic vec);
    if (sub) return vec ? `WAIT_SUB_VEC : `WAIT_SUB_NOVEC;
    return vec ? `WAIT_MAIN_VEC : `WAIT_MAIN_NOVEC;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic rd_reg(input logic [19:0] a, input logic b, input logic [2:0] i,
                        output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    bit_op_i <= b;
    bit_idx_i <= i;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic wr_reg(input logic [19:0] a, input logic b, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    bit_op_i <= b;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic wait_resume(input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while (resume_o !== 1'b1 && n < lim);
  endtask
  task automatic halt_pulse(input clk_src_t s);
    @(posedge clk_i);
    clk_src_i <= s;
    halt_exec_i <= 1'b1;
    @(posedge clk_i);
    halt_exec_i <= 1'b0;
  endtask
  task automatic stop_pulse(input clk_src_t s);
    @(posedge clk_i);
    clk_src_i <= s;
    stop_exec_i <= 1'b1;
    @(posedge clk_i);
    stop_exec_i <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    logic [2:0] c, j;
    logic sub, vec, won, wrun;
    int n;
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd_reg(`ADDR_SETTLE_STATUS, 1'b0, 3'h0, d);
    chk("status_rst", d, 8'h00);
    rd_reg(`ADDR_SETTLE_SELECT, 1'b0, 3'h0, d);
    chk("select_rst", d, 8'h07);
    rd_reg(20'hFFFA4, 1'b0, 3'h0, d);
    chk("unmapped", d, 8'h00);
    for (int k = 0; k < 8; k++) begin
      wr_reg(`ADDR_SETTLE_SELECT, 1'b0, {5'h1F, k[2:0]});
      rd_reg(`ADDR_SETTLE_SELECT, 1'b0, 3'h0, d);
      chk("select_code", d, {5'h00, k[2:0]});
    end
    wr_reg(`ADDR_SETTLE_SELECT, 1'b1, 8'h05);
    rd_reg(`ADDR_SETTLE_SELECT, 1'b0, 3'h0, d);
    chk("select_bitwr", d, 8'h07);
    wr_reg(`ADDR_SETTLE_STATUS, 1'b0, 8'hFF);
    rd_reg(`ADDR_SETTLE_STATUS, 1'b0, 3'h0, d);
    chk("status_ro", d, 8'h00);
    // settle count with a random code; codes below two are too short for this crystal
    seed = lfsr_next(seed);
    c = {2'b01, seed[0]};
    main_osc_halt_ctrl_i <= 1'b1;
    wr_reg(`ADDR_SETTLE_SELECT, 1'b0, {5'h00, c});
    osc_on <= 1'b1;
    main_osc_halt_ctrl_i <= 1'b0;
    repeat ((256 << c) * 5 - 60) @(posedge clk_i);
    rd_reg(`ADDR_SETTLE_STATUS, 1'b0, 3'h0, d);
    chk("status_early", d, therm(c) >> 1);
    repeat (300) @(posedge clk_i);
    rd_reg(`ADDR_SETTLE_STATUS, 1'b0, 3'h0, d);
    chk("status_done", d, therm(c));
    rd_reg(`ADDR_SETTLE_STATUS, 1'b1, c, d);
    chk("status_bit", d, 8'h01);
    rd_reg(`ADDR_SETTLE_STATUS, 1'b1, c + 3'h1, d);
    chk("status_bit_hi", d, 8'h00);
    main_osc_halt_ctrl_i <= 1'b1;
    rd_reg(`ADDR_SETTLE_STATUS, 1'b0, 3'h0, d);
    chk("status_main_osc_halt_ctrl", d, 8'h00);
    // halt entry and release from random sources
    for (int k = 0; k < 8; k++) begin
      seed = lfsr_next(seed);
      sub = (k % 4 == 3);
      vec = seed[3];
      won = seed[4];
      wrun = seed[5];
      j = seed[8:6];
      int_ack_en_i <= vec;
      watchdog_on_opt_i <= won;
      watchdog_standby_run_opt_i <= wrun;
      halt_pulse(sub ? SRC_SUB : clk_src_t'(seed[2:0] % 4));
      #1 chk("cpu_clk_off", cpu_clk_en_o, 1'b0);
      chk("standby", standby_o, 1'b1);
      chk("flash_lp", flash_lowpwr_o, sub);
      chk("adc_en", adc_en_o, !sub);
      chk("i2c_en", i2c_en_o, !sub);
      chk("lso_run", lso_run_o, won & wrun);
      chk("wdt_run", wdt_run_o, won & wrun);
      chk("x1_allow", x1_allow_o, clk_src_i != SRC_EXT);
      chk("ext_allow", ext_allow_o, clk_src_i != SRC_X1);
      chk("port_hold", port_hold_o, 1'b1);
      @(posedge clk_i);
      irq_flag_i <= 8'h01 << j;
      repeat (20) @(posedge clk_i);
      #1 chk("masked_stays", standby_o, 1'b1);
      @(posedge clk_i);
      irq_mask_i <= ~(8'h01 << j);
      wait_resume(40, n);
      chk("wake_wait", n, wake_w(sub, vec));
      chk("vector", vector_take_o, vec);
      chk("cpu_clk_on", cpu_clk_en_o, 1'b1);
      chk("lso_run_on", lso_run_o, 1'b1);
      chk("wdt_run_on", wdt_run_o, won);
      @(posedge clk_i);
      irq_flag_i <= 8'h00;
      irq_mask_i <= 8'hFF;
    end
    // request already pending at entry
    irq_flag_i <= 8'h10;
    irq_mask_i <= 8'hEF;
    int_ack_en_i <= 1'b0;
    halt_pulse(SRC_IH);
    wait_resume(40, n);
    chk("early_wake", n <= `WAIT_MAIN_NOVEC + 2, 1'b1);
    // stop on crystal clock waits for the selected settle time
    irq_mask_i <= 8'hFF;
    wr_reg(`ADDR_SETTLE_SELECT, 1'b0, 8'h02);
    main_osc_halt_ctrl_i <= 1'b0;
    stop_pulse(SRC_X1);
    rd_reg(`ADDR_SETTLE_STATUS, 1'b0, 3'h0, d);
    chk("status_stop", d, 8'h00);
    irq_mask_i <= 8'hEF;
    wait_resume(8000, n);
    chk("stop_wait", n > 5000 && n < 6000, 1'b1);
    rd_reg(`ADDR_SETTLE_STATUS, 1'b0, 3'h0, d);
    chk("status_wake", d, therm(3'h2));
    // stop on internal clock: software polls the status after release
    irq_mask_i <= 8'hFF;
    stop_pulse(SRC_IH);
    rd_reg(`ADDR_SETTLE_STATUS, 1'b0, 3'h0, d);
    chk("status_stop_ih", d, 8'h00);
    irq_mask_i <= 8'hEF;
    wait_resume(40, n);
    chk("stop_ih_wake", n, `WAIT_MAIN_NOVEC);
    irq_mask_i <= 8'hFF;
    n = 0;
    do begin
      rd_reg(`ADDR_SETTLE_STATUS, 1'b1, 3'h2, d);
      n++;
    end while (d !== 8'h01 && n < 4000);
    chk("poll_len", n > 2400 && n < 2700, 1'b1);
    rd_reg(`ADDR_SETTLE_STATUS, 1'b0, 3'h0, d);
    chk("status_poll", d, therm(3'h2));
    // reset while halted
    irq_mask_i <= 8'hFF;
    irq_flag_i <= 8'h00;
    wr_reg(`ADDR_SETTLE_SELECT, 1'b0, 8'h03);
    halt_pulse(SRC_IH);
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    #1 chk("rst_standby", standby_o, 1'b0);
    chk("rst_cpu_clk", cpu_clk_en_o, 1'b1);
    rd_reg(`ADDR_SETTLE_SELECT, 1'b0, 3'h0, d);
    chk("rst_select", d, 8'h07);
    print_verdict();
  end
endmodule

/* File: x1_osc_model.sv */
// crystal oscillator model standing on the far side of the settle counter
`timescale 1ns/1ps
module x1_osc_model #(
  parameter int HALF_NS = 10,
  parameter int START_NS = 200
) (
  input wire logic en_i, // oscillator powered and allowed
  output logic x1_o // crystal clock pin
);
  initial begin
    x1_o = 1'b0;
    forever begin
      wait (en_i === 1'b1);
      // start-up interval gives no edges at all
      #(START_NS);
      while (en_i === 1'b1) begin
        #(HALF_NS) x1_o = ~x1_o;
      end
      // a stopped crystal stands still at low
      x1_o = 1'b0;
    end
  end
endmodule
